// [core/ccf_branch_eval.sv]
// branch condition evaluator over negative, zero, overflow and carry
`timescale 1ns/1ps
module ccf_branch_eval
   import ccf_pkg::*;
(
   // flags
   input  wire logic      neg,
   input  wire logic      zero,
   input  wire logic      ovf,
   input  wire logic      carry,
   // condition
   input  wire ccf_cond_t cond,
   output logic           taken
);
   always_comb begin
      unique case (cond)
         CCF_BR_T:  taken = 1'b1;
         CCF_BR_F:  taken = 1'b0;
         CCF_BR_HI: taken = ~(carry | zero);
         CCF_BR_LS: taken = carry | zero;
         CCF_BR_CC: taken = ~carry;
         CCF_BR_CS: taken = carry;
         CCF_BR_NE: taken = ~zero;
         CCF_BR_EQ: taken = zero;
         CCF_BR_VC: taken = ~ovf;
         CCF_BR_VS: taken = ovf;
         CCF_BR_PL: taken = ~neg;
         CCF_BR_MI: taken = neg;
         CCF_BR_GE: taken = ~(neg ^ ovf);
         CCF_BR_LT: taken = neg ^ ovf;
         CCF_BR_GT: taken = ~(zero | (neg ^ ovf));
         CCF_BR_LE: taken = zero | (neg ^ ovf);
      endcase
   end
endmodule

// [core/ccf_flags.sv]
// condition code register with flag generation, masking and branch test
`timescale 1ns/1ps
`include "ccf_map.svh"
module ccf_flags
   import ccf_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // control register instructions
   input  wire ccf_ctl_t    ctl_op,
   input  wire logic [7:0]  ctl_imm,
   output logic [7:0]       condition_code_register,
   // arithmetic result interface
   input  wire ccf_op_t     alu_op,
   input  wire ccf_size_t   alu_size,
   input  wire logic [31:0] alu_a,
   input  wire logic [31:0] alu_b,
   input  wire logic [31:0] alu_result,
   input  wire logic        alu_carry_out,
   input  wire logic        alu_overflow,
   input  wire logic        shift_out_bit,
   input  wire logic        upd_half,
   input  wire logic        upd_neg,
   input  wire logic        upd_zero,
   input  wire logic        upd_ovf,
   input  wire logic        upd_carry,
   // bit manipulation accumulator
   input  wire ccf_bop_t    bit_op,
   input  wire logic        bit_operand,
   output logic             bit_acc,
   // exception and interrupt gating
   input  wire logic        exc_start,
   input  wire logic        irq_req,
   input  wire logic        nmi_req,
   output logic             irq_accept,
   output logic             nmi_accept,
   // branch test
   input  wire ccf_cond_t   br_cond,
   output logic             br_taken
);
   logic       mask_ff;
   logic       umask_ff;
   logic       half_ff;
   logic       user_ff;
   logic       neg_ff;
   logic       zero_ff;
   logic       ovf_ff;
   logic       carry_ff;
   logic [7:0] cur;
   logic [7:0] ctl_val;
   logic       hc;
   logic       sign;
   logic       is_zero;
   logic       ctl_wr;
   logic       bit_wr;
   logic       alu_wr;
   logic       bit_res;
   logic       shift_op;

   // carry into bit pos+1 of a+b (or borrow of a-b): sum bit xor operand bits
   function automatic logic carry_at(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [31:0] r,
                                     input int unsigned pos);
      logic [31:0] x;
      x = a ^ b ^ r;
      return x[pos + 1];
   endfunction

   // add, subtract, compare and negate families own half-carry and overflow
   function automatic logic is_arith(input ccf_op_t op);
      return (op == CCF_OP_ADD) || (op == CCF_OP_ADD_WITH_EXTEND) ||
             (op == CCF_OP_SUB) || (op == CCF_OP_SUBTRACT_WITH_EXTEND) ||
             (op == CCF_OP_CMP) || (op == CCF_OP_NEG);
   endfunction

   // extend forms chain a multi-byte result through the stored carry and zero
   function automatic logic is_extend(input ccf_op_t op);
      return (op == CCF_OP_ADD_WITH_EXTEND) || (op == CCF_OP_SUBTRACT_WITH_EXTEND);
   endfunction

   assign cur = {mask_ff, umask_ff, half_ff, user_ff,
                 neg_ff, zero_ff, ovf_ff, carry_ff};
   assign condition_code_register = cur;

   always_comb begin
      unique case (ctl_op)
         CCF_CTL_LOAD: ctl_val = ctl_imm;
         CCF_CTL_AND:  ctl_val = cur & ctl_imm;
         CCF_CTL_OR:   ctl_val = cur | ctl_imm;
         CCF_CTL_XOR:  ctl_val = cur ^ ctl_imm;
         default:      ctl_val = cur;
      endcase
   end

   // half-carry tap chosen by operand size
   always_comb begin
      unique case (alu_size)
         CCF_SZ_BYTE: hc = carry_at(alu_a, alu_b, alu_result, `CCF_HC_BYTE);
         CCF_SZ_WORD: hc = carry_at(alu_a, alu_b, alu_result, `CCF_HC_WORD);
         CCF_SZ_LONG: hc = carry_at(alu_a, alu_b, alu_result, `CCF_HC_LONG);
         default:     hc = 1'b0;
      endcase
   end

   always_comb begin
      unique case (alu_size)
         CCF_SZ_BYTE: begin
            sign    = alu_result[7];
            is_zero = (alu_result[7:0] == 8'h00);
         end
         CCF_SZ_WORD: begin
            sign    = alu_result[15];
            is_zero = (alu_result[15:0] == 16'h0000);
         end
         default: begin
            sign    = alu_result[31];
            is_zero = (alu_result == 32'h0000_0000);
         end
      endcase
   end

   // a control write takes the edge from the datapath, whose result is dropped then; only exception entry beats it on the mask
   assign ctl_wr   = (ctl_op != CCF_CTL_NONE);
   assign bit_wr   = ~ctl_wr & (alu_op == CCF_OP_BIT);
   assign alu_wr   = ~ctl_wr & (alu_op != CCF_OP_NONE) & (alu_op != CCF_OP_BIT);
   assign shift_op = (alu_op == CCF_OP_SHIFT);

   // one-bit accumulator result of a bit instruction
   always_comb begin
      unique case (bit_op)
         CCF_BOP_LOAD: bit_res = bit_operand;
         CCF_BOP_AND:  bit_res = carry_ff & bit_operand;
         CCF_BOP_OR:   bit_res = carry_ff | bit_operand;
         CCF_BOP_XOR:  bit_res = carry_ff ^ bit_operand;
         default:      bit_res = carry_ff;
      endcase
   end

   // bit accumulator is the current carry flag
   assign bit_acc = carry_ff;

   // exception entry wins over a concurrent software write of the mask
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mask_ff <= `CCF_MASK_RST;
      end else if (exc_start) begin
         mask_ff <= 1'b1;
      end else if (ctl_wr) begin
         mask_ff <= ctl_val[`CCF_BIT_MASK];
      end
   end

   // bits below the mask carry no architectural reset; they are cleared only so
   // that simulation starts from known values
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         umask_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         umask_ff <= ctl_val[`CCF_BIT_UMASK];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         user_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         user_ff <= ctl_val[`CCF_BIT_USER];
      end
   end

   // logic and shift classes clear half-carry when told to touch it; bit instructions leave it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         half_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         half_ff <= ctl_val[`CCF_BIT_HALF];
      end else if (alu_wr && upd_half) begin
         half_ff <= is_arith(alu_op) & hc;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         neg_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         neg_ff <= ctl_val[`CCF_BIT_NEG];
      end else if (alu_wr && upd_neg) begin
         neg_ff <= sign;
      end
   end

   // extend forms only keep zero set, so a chained multi-byte result tests as a whole
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         zero_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         zero_ff <= ctl_val[`CCF_BIT_ZERO];
      end else if (alu_wr && upd_zero && is_extend(alu_op)) begin
         zero_ff <= zero_ff & is_zero;
      end else if (alu_wr && upd_zero) begin
         zero_ff <= is_zero;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         ovf_ff <= ctl_val[`CCF_BIT_OVF];
      end else if (alu_wr && upd_ovf) begin
         ovf_ff <= is_arith(alu_op) & alu_overflow;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         carry_ff <= `CCF_FLAG_RST;
      end else if (ctl_wr) begin
         carry_ff <= ctl_val[`CCF_BIT_CARRY];
      end else if (bit_wr) begin
         carry_ff <= bit_res;
      end else if (alu_wr && upd_carry && shift_op) begin
         carry_ff <= shift_out_bit;
      end else if (alu_wr && upd_carry) begin
         carry_ff <= alu_carry_out;
      end
   end

   assign irq_accept = irq_req & ~mask_ff;
   assign nmi_accept = nmi_req;

   ccf_branch_eval u_branch (
      .neg   (neg_ff),
      .zero  (zero_ff),
      .ovf   (ovf_ff),
      .carry (carry_ff),
      .cond  (br_cond),
      .taken (br_taken)
   );
endmodule

// [core/ccf_map.svh]
// offsets, field positions and reset values for the condition code flag block
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH
`define CCF_WIDTH      8
`define CCF_BIT_MASK   7
`define CCF_BIT_UMASK  6
`define CCF_BIT_HALF   5
`define CCF_BIT_USER   4
`define CCF_BIT_NEG    3
`define CCF_BIT_ZERO   2
`define CCF_BIT_OVF    1
`define CCF_BIT_CARRY  0
`define CCF_MASK_RST   1'h1
`define CCF_FLAG_RST   1'h0
`define CCF_HC_BYTE    3
`define CCF_HC_WORD    11
`define CCF_HC_LONG    27
`endif

// [core/ccf_pkg.sv]
// types for the condition code flag block
package ccf_pkg;
   typedef enum logic [1:0] {CCF_SZ_BYTE, CCF_SZ_WORD, CCF_SZ_LONG} ccf_size_t;
   typedef enum logic [3:0] {
      CCF_OP_NONE, CCF_OP_ADD, CCF_OP_ADD_WITH_EXTEND, CCF_OP_SUB,
      CCF_OP_SUBTRACT_WITH_EXTEND, CCF_OP_CMP,
      CCF_OP_NEG, CCF_OP_LOGIC, CCF_OP_SHIFT, CCF_OP_BIT
   } ccf_op_t;
   typedef enum logic [2:0] {
      CCF_CTL_NONE, CCF_CTL_LOAD, CCF_CTL_AND, CCF_CTL_OR, CCF_CTL_XOR
   } ccf_ctl_t;
   typedef enum logic [3:0] {
      CCF_BR_T, CCF_BR_F, CCF_BR_HI, CCF_BR_LS, CCF_BR_CC, CCF_BR_CS, CCF_BR_NE, CCF_BR_EQ,
      CCF_BR_VC, CCF_BR_VS, CCF_BR_PL, CCF_BR_MI, CCF_BR_GE, CCF_BR_LT, CCF_BR_GT, CCF_BR_LE
   } ccf_cond_t;
   typedef enum logic [2:0] {
      CCF_BOP_LOAD, CCF_BOP_AND, CCF_BOP_OR, CCF_BOP_XOR, CCF_BOP_KEEP
   } ccf_bop_t;
endpackage

// [sim/ccf_flags_props.sv]
// concurrent checks on the condition code flag block ports
`timescale 1ns/1ps
module ccf_flags_props
   import ccf_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        arst_n,
   // requests
   input wire ccf_ctl_t    ctl_op,
   input wire logic [7:0]  ctl_imm,
   input wire ccf_op_t     alu_op,
   input wire ccf_size_t   alu_size,
   input wire logic [31:0] alu_result,
   input wire logic        alu_carry_out,
   input wire logic        upd_neg,
   input wire logic        upd_carry,
   input wire logic        exc_start,
   input wire logic        irq_req,
   input wire logic        nmi_req,
   // answers
   input wire logic        irq_accept,
   input wire logic        nmi_accept,
   input wire logic        bit_acc,
   input wire logic [7:0]  condition_code_register
);
   logic [7:0] q;
   logic       add;
   assign q = condition_code_register;
   // a control write steals the edge from the datapath
   assign add = ctl_op == CCF_CTL_NONE && alu_op == CCF_OP_ADD;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_irq_gate: assert property (irq_accept == (irq_req && !q[7]))
      else $error("irq gate");
   a_nmi_pass: assert property (nmi_accept == nmi_req)
      else $error("nmi pass");
   a_exc_mask: assert property (exc_start |=> q[7])
      else $error("exc mask");
   a_ctl_load: assert property (ctl_op == CCF_CTL_LOAD && !exc_start
      |=> q == $past(ctl_imm))
      else $error("ctl load");
   a_idle_hold: assert property (ctl_op == CCF_CTL_NONE && alu_op == CCF_OP_NONE
      && !exc_start |=> $stable(q))
      else $error("idle hold");
   a_acc_carry: assert property (bit_acc == q[0])
      else $error("acc carry");
   a_neg_sign: assert property (add && upd_neg && alu_size == CCF_SZ_LONG
      |=> q[3] == $past(alu_result[31]))
      else $error("neg sign");
   a_carry_add: assert property (add && upd_carry |=> q[0] == $past(alu_carry_out))
      else $error("carry add");
   c_exc_ctl: cover property (exc_start && ctl_op != CCF_CTL_NONE);
   c_irq_open: cover property (irq_req && !q[7]);
   c_add_long: cover property (add && upd_neg && alu_size == CCF_SZ_LONG);
endmodule
bind ccf_flags ccf_flags_props chk (
   .mclk                    (mclk),
   .arst_n                  (arst_n),
   .ctl_op                  (ctl_op),
   .ctl_imm                 (ctl_imm),
   .alu_op                  (alu_op),
   .alu_size                (alu_size),
   .alu_result              (alu_result),
   .alu_carry_out           (alu_carry_out),
   .upd_neg                 (upd_neg),
   .upd_carry               (upd_carry),
   .exc_start               (exc_start),
   .irq_req                 (irq_req),
   .nmi_req                 (nmi_req),
   .irq_accept              (irq_accept),
   .nmi_accept              (nmi_accept),
   .bit_acc                 (bit_acc),
   .condition_code_register (condition_code_register)
);

// [sim/testbench.sv]
// random bench with a flag model for the condition code block
`timescale 1ns/1ps
module testbench
   import ccf_pkg::*;
;
   logic        mclk = '0, arst_n = '0, exc_start = '0, irq_req = '0, nmi_req = '0;
   logic        bit_operand = '0, alu_carry_out = '0, alu_overflow = '0, shift_out_bit = '0;
   logic        upd_half = '0, upd_neg = '0, upd_zero = '0, upd_ovf = '0, upd_carry = '0;
   logic        irq_accept, nmi_accept, bit_acc, br_taken, rs;
   logic [7:0]  ctl_imm = '0, condition_code_register, e, m = 8'h80;
   logic [31:0] alu_a = '0, alu_b = '0, alu_result = '0, v, a, b;
   ccf_ctl_t    ctl_op = CCF_CTL_NONE;
   ccf_op_t     alu_op = CCF_OP_NONE;
   ccf_size_t   alu_size = CCF_SZ_BYTE;
   ccf_bop_t    bit_op = CCF_BOP_KEEP;
   ccf_cond_t   br_cond = CCF_BR_T;
   int          seed = 26571, miscompares = 0, compares = 0;
   ccf_flags uut (
      .mclk                    (mclk),
      .arst_n                  (arst_n),
      .ctl_op                  (ctl_op),
      .ctl_imm                 (ctl_imm),
      .condition_code_register (condition_code_register),
      .alu_op                  (alu_op),
      .alu_size                (alu_size),
      .alu_a                   (alu_a),
      .alu_b                   (alu_b),
      .alu_result              (alu_result),
      .alu_carry_out           (alu_carry_out),
      .alu_overflow            (alu_overflow),
      .shift_out_bit           (shift_out_bit),
      .upd_half                (upd_half),
      .upd_neg                 (upd_neg),
      .upd_zero                (upd_zero),
      .upd_ovf                 (upd_ovf),
      .upd_carry               (upd_carry),
      .bit_op                  (bit_op),
      .bit_operand             (bit_operand),
      .bit_acc                 (bit_acc),
      .exc_start               (exc_start),
      .irq_req                 (irq_req),
      .nmi_req                 (nmi_req),
      .irq_accept              (irq_accept),
      .nmi_accept              (nmi_accept),
      .br_cond                 (br_cond),
      .br_taken                (br_taken)
   );
   initial forever #12.5 mclk = ~mclk;
   task automatic chk_reg(input logic [7:0] x, g);
      compares++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %0t exp %h got %h", $time, x, g);
      end
   endtask
   task automatic chk_bit(input logic x, g);
      chk_reg({7'h0, x}, {7'h0, g});
   endtask
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // the edge takes what was driven before it
   task automatic step();
      logic [7:0]  n;
      logic [32:0] s;
      logic [31:0] k, r;
      logic        ar, ex;
      int          p;
      n = m;
      p = alu_size == CCF_SZ_BYTE ? 3 : alu_size == CCF_SZ_WORD ? 11 : 27;
      k = (32'h1 << (p + 1)) - 32'h1;
      ar = alu_op >= CCF_OP_ADD && alu_op <= CCF_OP_NEG;
      ex = alu_op == CCF_OP_ADD_WITH_EXTEND || alu_op == CCF_OP_SUBTRACT_WITH_EXTEND;
      s = alu_op >= CCF_OP_SUB && alu_op <= CCF_OP_NEG ? (alu_a & k) - (alu_b & k) - (ex & m[0])
         : (alu_a & k) + (alu_b & k) + (ex & m[0]);
      r = alu_result << (27 - p);
      case (ctl_op)
         CCF_CTL_LOAD: n = ctl_imm;
         CCF_CTL_AND: n = m & ctl_imm;
         CCF_CTL_OR: n = m | ctl_imm;
         CCF_CTL_XOR: n = m ^ ctl_imm;
         default: if (alu_op == CCF_OP_BIT) begin
            n[0] = bit_op == CCF_BOP_LOAD ? bit_operand : bit_op == CCF_BOP_AND ? m[0] & bit_operand
               : bit_op == CCF_BOP_OR ? m[0] | bit_operand
               : bit_op == CCF_BOP_XOR ? m[0] ^ bit_operand : m[0];
         end else if (alu_op != CCF_OP_NONE) begin
            if (upd_half) n[5] = ar & s[p + 1];
            if (upd_neg) n[3] = r[31];
            if (upd_zero) n[2] = r == 0 && (!ex || m[2]);
            if (upd_ovf) n[1] = ar & alu_overflow;
            if (upd_carry) n[0] = alu_op == CCF_OP_SHIFT ? shift_out_bit : alu_carry_out;
         end
      endcase
      if (exc_start) n[7] = 1'h1;
      m = n;
   endtask
   task automatic drive();
      ccf_op_t o;
      v = $random(seed);
      a = $random(seed);
      b = $random(seed);
      o = ccf_op_t'(v[3:0] % 10);
      if (o == CCF_OP_NEG) a = '0;
      // extend ops must carry in the flag that will stand at their edge
      alu_result <= o >= CCF_OP_SUB && o <= CCF_OP_NEG
         ? a - b - (o == CCF_OP_SUBTRACT_WITH_EXTEND & m[0])
         : a + b + (o == CCF_OP_ADD_WITH_EXTEND & m[0]);
      alu_op <= o;
      alu_a <= a;
      alu_b <= b;
      alu_size <= o == CCF_OP_ADD_WITH_EXTEND || o == CCF_OP_SUBTRACT_WITH_EXTEND
         ? CCF_SZ_BYTE : ccf_size_t'(v[5:4] % 3);
      {upd_half, upd_neg, upd_zero, upd_ovf, upd_carry} <= o == CCF_OP_BIT ? 5'h01
         : v[10:6] & {4'hf, o != CCF_OP_LOGIC};
      bit_op <= ccf_bop_t'(v[13:11] % 5);
      ctl_op <= ccf_ctl_t'(v[15:14] == 0 ? v[17:16] + 1 : 0);
      ctl_imm <= b[15:8];
      {exc_start, irq_req, nmi_req, bit_operand, alu_carry_out, alu_overflow, shift_out_bit}
         <= {v[21:18] == 0, v[27:22]};
      br_cond <= ccf_cond_t'(v[31:28]);
   endtask
   initial begin
      for (int i = 0; i < 3000; i++) begin
         @(posedge mclk);
         if (arst_n) step();
         drive();
         rs = i < 4 || i == 2000 || i == 2001;
         arst_n <= !rs;
         if (rs) m = 8'h80;
         #2;
         e = {~(m[2] | (m[3] ^ m[1])), ~(m[3] ^ m[1]), ~m[3], ~m[1],
              ~m[2], ~m[0], ~(m[0] | m[2]), 1'h1};
         chk_reg(m, condition_code_register);
         chk_bit(irq_req & ~m[7], irq_accept);
         chk_bit(nmi_req, nmi_accept);
         chk_bit(m[0], bit_acc);
         chk_bit(e[br_cond[3:1]] ^ br_cond[0], br_taken);
      end
      wrap_up();
   end
   initial begin
      #100000;
      miscompares++;
      wrap_up();
   end
endmodule
